// >>> inc/tsr_defs.vh
/*
 * offsets, field positions, reset values and step encodings of the
 * trigger sequencer register set.
 * assumes: included by the register set module by its bare name.
 */
`ifndef TSR_DEFS_VH
`define TSR_DEFS_VH

// ------------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------------
`define TSR_OFF_BTE       8'h00
`define TSR_OFF_T0LIM     8'h04
`define TSR_OFF_T1LIM     8'h08
`define TSR_OFF_SDLIM     8'h0C
`define TSR_OFF_C0LIM     8'h10
`define TSR_OFF_C1LIM     8'h14
`define TSR_OFF_HOLD      8'h18
`define TSR_OFF_ADJ       8'h1C
`define TSR_OFF_LIT       8'h20
`define TSR_OFF_QPTR      8'h24
`define TSR_OFF_CTRL      8'h28
`define TSR_OFF_STATUS    8'h2C
`define TSR_OFF_QUE0      8'h40
`define TSR_QUE_IDX_HI    4
`define TSR_QUE_IDX_LO    2

// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define TSR_BTE_CLK1_BIT  4
`define TSR_BTE_SYNC_W    4
`define TSR_QPTR_W        5
`define TSR_CTRL_EN_BIT   0
`define TSR_CTRL_ST_BIT   1
`define TSR_RST_16        16'h0000

// ------------------------------------------------------------------
// step command and option codes
// ------------------------------------------------------------------
`define TSR_CMD_CTRL      4'h0
`define TSR_CMD_ADD       4'h1
`define TSR_CMD_JMPC0     3'h6
`define TSR_CMD_JMPC1     3'h7
`define TSR_OPT_SD_OFF    4'h2
`define TSR_OPT_SD_ON     4'h6
`define TSR_OPT_T0_WAIT   4'h8
`define TSR_OPT_T1_WAIT   4'h9
`define TSR_OPT_CHS_C0    4'hC
`define TSR_OPT_CHS_C1    4'hD
`define TSR_OPT_CHS_LIT   4'hE
`define TSR_OPT_BCAST     4'hF
`define TSR_TGT_C0        3'h0
`define TSR_TGT_C1        3'h1
`define TSR_TGT_T0        3'h2
`define TSR_TGT_T1        3'h3
`define TSR_TGT_SD        3'h4
`define TSR_TGT_LIT       3'h5

`endif

// >>> rtl/tsr_register_set.v
/*
 * register set of a peripheral trigger sequencer with a compact step
 * engine that consumes it, behind an ahb-lite slave.
 * assumes: one master, single word transfers, one clock, clk_en high
 * to run.
 */
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tsr_defs.vh"

module tsr_register_set #(
    parameter QUE_WORDS = 8
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    output reg  [3:0]  compare_sync_pulse,
    output reg         compare1_clock_pulse,
    output reg  [15:0] converter_channel_select,
    output reg         converter_channel_load
);

    // ------------------------------------------------------------------
    // stored registers
    // ------------------------------------------------------------------
    reg  [15:0] broadcast_trigger_enable;
    reg  [15:0] timer_zero_limit;
    reg  [15:0] timer_one_limit;
    reg  [15:0] step_delay_limit;
    reg  [15:0] counter_zero_limit;
    reg  [15:0] counter_one_limit;
    reg  [15:0] copy_source_hold;
    reg  [15:0] add_source_adjust;
    reg  [15:0] channel_literal_zero;
    reg  [4:0]  step_queue_pointer;
    reg  [15:0] step_queue_word [0:QUE_WORDS-1];
    reg         sequencer_enable;
    reg         sequencer_start;

    // engine state
    reg  [15:0] counter_zero;
    reg  [15:0] counter_one;
    reg  [15:0] timer_count;
    reg  [15:0] delay_count;
    reg         step_delay_on;
    reg  [15:0] timer_lim_q;
    reg  [1:0]  state;

    localparam [1:0] ST_FETCH = 2'b00;
    localparam [1:0] ST_WAIT  = 2'b01;
    localparam [1:0] ST_DELAY = 2'b10;

    // ------------------------------------------------------------------
    // ahb-lite address phase capture
    // ------------------------------------------------------------------
    reg         wr_pend;
    reg  [7:0]  wr_addr;
    reg  [7:0]  rd_addr;
    wire        running;
    wire        addr_ok;
    wire        rd_req;

    assign running   = sequencer_enable & sequencer_start;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel & hready & htrans[1];
    assign rd_req    = addr_ok & ~hwrite;

    always @(posedge clk) begin
        if (!resetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (clk_en) begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // ------------------------------------------------------------------
    // read mux, registered into the data phase
    // ------------------------------------------------------------------
    reg  [15:0] rd_val;
    always @* begin
        rd_val = 16'h0000;
        case (haddr[7:0])
            `TSR_OFF_BTE:    rd_val = broadcast_trigger_enable;
            `TSR_OFF_T0LIM:  rd_val = timer_zero_limit;
            `TSR_OFF_T1LIM:  rd_val = timer_one_limit;
            `TSR_OFF_SDLIM:  rd_val = step_delay_limit;
            `TSR_OFF_C0LIM:  rd_val = counter_zero_limit;
            `TSR_OFF_C1LIM:  rd_val = counter_one_limit;
            `TSR_OFF_HOLD:   rd_val = copy_source_hold;
            `TSR_OFF_ADJ:    rd_val = add_source_adjust;
            `TSR_OFF_LIT:    rd_val = channel_literal_zero;
            `TSR_OFF_QPTR:   rd_val = {11'h000, step_queue_pointer};
            `TSR_OFF_CTRL:   rd_val = {14'h0000, sequencer_start, sequencer_enable};
            `TSR_OFF_STATUS: rd_val = {14'h0000, state};
            default: begin
                if (haddr[7:5] == 3'b010)
                    rd_val = step_queue_word[haddr[`TSR_QUE_IDX_HI:`TSR_QUE_IDX_LO]];
                else
                    rd_val = 16'h0000;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!resetn)
            hrdata <= 32'h0000_0000;
        else if (clk_en && rd_req)
            hrdata <= {16'h0000, rd_val};
    end

    // ------------------------------------------------------------------
    // step decode
    // ------------------------------------------------------------------
    wire [15:0] cur_word;
    wire [7:0]  step;
    wire [3:0]  cmd;
    wire [3:0]  opt;
    wire [4:0]  jmp_target;
    wire        sw_wr;
    wire [15:0] wd;

    // odd step upper byte, even step lower byte
    assign cur_word   = step_queue_word[step_queue_pointer[3:1]];
    assign step       = step_queue_pointer[0] ? cur_word[15:8] : cur_word[7:0];
    assign cmd        = step[7:4];
    assign opt        = step[3:0];
    assign jmp_target = {cmd[0], opt};
    assign sw_wr      = wr_pend & ~running;
    assign wd         = hwdata[15:0];

    wire is_add  = (cmd == `TSR_CMD_ADD) && !opt[3];
    wire is_copy = (cmd == `TSR_CMD_ADD) && opt[3];
    wire is_ctrl = (cmd == `TSR_CMD_CTRL);
    wire is_tw   = is_ctrl && (opt == `TSR_OPT_T0_WAIT || opt == `TSR_OPT_T1_WAIT);
    wire [15:0] timer_lim = opt[0] ? timer_one_limit : timer_zero_limit;
    wire [2:0]  tgt       = opt[2:0];

    function [15:0] upd;
        input [15:0] cur;
        begin
            upd = is_copy ? copy_source_hold : cur + add_source_adjust;
        end
    endfunction

    wire do_mod = running && state == ST_FETCH && (is_add || is_copy);

    // zero limit skips delay
    // the fetch cycle already is the one base clock of a step
    wire delay_go = step_delay_on && (step_delay_limit != 16'h0000);

    // ------------------------------------------------------------------
    // limit, source and control registers
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            broadcast_trigger_enable <= `TSR_RST_16;
            timer_zero_limit         <= `TSR_RST_16;
            timer_one_limit          <= `TSR_RST_16;
            step_delay_limit         <= `TSR_RST_16;
            counter_zero_limit       <= `TSR_RST_16;
            counter_one_limit        <= `TSR_RST_16;
            copy_source_hold         <= `TSR_RST_16;
            add_source_adjust        <= `TSR_RST_16;
            channel_literal_zero     <= `TSR_RST_16;
            sequencer_enable         <= 1'b0;
            sequencer_start          <= 1'b0;
        end else if (clk_en) begin
            if (sw_wr) begin
                case (wr_addr)
                    `TSR_OFF_BTE:   broadcast_trigger_enable <= wd;
                    `TSR_OFF_T0LIM: timer_zero_limit         <= wd;
                    `TSR_OFF_T1LIM: timer_one_limit          <= wd;
                    `TSR_OFF_SDLIM: step_delay_limit         <= wd;
                    `TSR_OFF_C0LIM: counter_zero_limit       <= wd;
                    `TSR_OFF_C1LIM: counter_one_limit        <= wd;
                    `TSR_OFF_HOLD:  copy_source_hold         <= wd;
                    `TSR_OFF_ADJ:   add_source_adjust        <= wd;
                    `TSR_OFF_LIT:   channel_literal_zero     <= wd;
                    default: ;
                endcase
            end
            // control stays writable so software can stop the engine
            if (wr_pend && wr_addr == `TSR_OFF_CTRL) begin
                sequencer_enable <= wd[`TSR_CTRL_EN_BIT];
                sequencer_start  <= wd[`TSR_CTRL_ST_BIT];
            end
            if (do_mod) begin
                case (tgt)
                    `TSR_TGT_C0:  counter_zero_limit   <= upd(counter_zero_limit);
                    `TSR_TGT_C1:  counter_one_limit    <= upd(counter_one_limit);
                    `TSR_TGT_T0:  timer_zero_limit     <= upd(timer_zero_limit);
                    `TSR_TGT_T1:  timer_one_limit      <= upd(timer_one_limit);
                    `TSR_TGT_SD:  step_delay_limit     <= upd(step_delay_limit);
                    `TSR_TGT_LIT: channel_literal_zero <= upd(channel_literal_zero);
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // step queue, no reset
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < QUE_WORDS; gi = gi + 1) begin : g_que
            always @(posedge clk) begin
                if (clk_en && sw_wr && wr_addr[7:5] == 3'b010
                    && wr_addr[`TSR_QUE_IDX_HI:`TSR_QUE_IDX_LO] == gi)
                    step_queue_word[gi] <= wd;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // step engine
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            state                    <= ST_FETCH;
            step_queue_pointer       <= 5'h00;
            counter_zero             <= 16'h0000;
            counter_one              <= 16'h0000;
            timer_count              <= 16'h0000;
            delay_count              <= 16'h0000;
            step_delay_on            <= 1'b0;
            compare_sync_pulse       <= 4'h0;
            compare1_clock_pulse     <= 1'b0;
            converter_channel_select <= 16'h0000;
            converter_channel_load   <= 1'b0;
        end else if (clk_en) begin
            compare_sync_pulse     <= 4'h0;
            compare1_clock_pulse   <= 1'b0;
            converter_channel_load <= 1'b0;
            if (!running) begin
                state <= ST_FETCH;
                if (sw_wr && wr_addr == `TSR_OFF_QPTR)
                    step_queue_pointer <= wd[`TSR_QPTR_W-1:0];
            end else begin
                case (state)
                    ST_FETCH: begin
                        step_queue_pointer <= step_queue_pointer + 5'h01;
                        // fetch counts as first clock of the step
                        delay_count        <= 16'h0001;
                        timer_count        <= 16'h0000;
                        if (is_ctrl) begin
                            case (opt)
                                `TSR_OPT_SD_OFF: step_delay_on <= 1'b0;
                                `TSR_OPT_SD_ON:  step_delay_on <= 1'b1;
                                `TSR_OPT_CHS_C0: begin
                                    converter_channel_select <= counter_zero;
                                    converter_channel_load   <= 1'b1;
                                end
                                `TSR_OPT_CHS_C1: begin
                                    converter_channel_select <= counter_one;
                                    converter_channel_load   <= 1'b1;
                                end
                                `TSR_OPT_CHS_LIT: begin
                                    converter_channel_select <= channel_literal_zero;
                                    converter_channel_load   <= 1'b1;
                                end
                                `TSR_OPT_BCAST: begin
                                    compare1_clock_pulse <=
                                        broadcast_trigger_enable[`TSR_BTE_CLK1_BIT];
                                    compare_sync_pulse   <=
                                        broadcast_trigger_enable[`TSR_BTE_SYNC_W-1:0];
                                end
                                default: ;
                            endcase
                        end
                        if (cmd[3:1] == `TSR_CMD_JMPC0) begin
                            if (counter_zero != counter_zero_limit) begin
                                counter_zero       <= counter_zero + 16'h0001;
                                step_queue_pointer <= jmp_target;
                            end else
                                counter_zero <= 16'h0000;
                        end
                        if (cmd[3:1] == `TSR_CMD_JMPC1) begin
                            if (counter_one != counter_one_limit) begin
                                counter_one        <= counter_one + 16'h0001;
                                step_queue_pointer <= jmp_target;
                            end else
                                counter_one <= 16'h0000;
                        end
                        if (is_tw)
                            state <= ST_WAIT;
                        else if (delay_go)
                            state <= ST_DELAY;
                    end
                    // timer zero limit in wait step
                    // timer one limit in wait step
                    ST_WAIT: begin
                        if (timer_count == timer_lim_q)
                            state <= delay_go ? ST_DELAY : ST_FETCH;
                        else
                            timer_count <= timer_count + 16'h0001;
                    end
                    // step delay of limit plus one
                    ST_DELAY: begin
                        // at-or-above, so a limit lowered mid-delay cannot wrap
                        if (delay_count >= step_delay_limit)
                            state <= ST_FETCH;
                        else
                            delay_count <= delay_count + 16'h0001;
                    end
                    default: state <= ST_FETCH;
                endcase
            end
        end
    end

    // timer limit latched at the wait step, pointer has moved on
    always @(posedge clk) begin
        if (!resetn)
            timer_lim_q <= 16'h0000;
        else if (clk_en && running && state == ST_FETCH && is_tw)
            timer_lim_q <= timer_lim;
    end

endmodule

// >>> verification/tb_top.sv
/*
 * self-checking bench of the trigger sequencer register set.
 * assumes: design and checker compiled before it.
 */
`timescale 1ns/1ps
`include "tsr_defs.vh"
module tb_top;
    localparam logic [15:0] H = 16'h1200, A = 16'h0034, SD = 16'h0003, C0 = 16'h0002;
    logic        clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
    wire         hsel, hwrite, hreadyout, hresp, c1_clk, ch_load;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [1:0]  htrans;
    wire  [2:0]  hsize;
    wire  [3:0]  sync;
    wire  [15:0] sel;
    logic [31:0] rd, n_clk = 0, n_ld = 0, n_sy [4] = '{default: 0};
    int          fails = 0, cmp_count = 0, cyc = 0, t_prev = 0, t_last = 0;
    logic [55:0] rows [11] = '{
        {`TSR_OFF_BTE, 16'h0015, 32'h00000015}, {`TSR_OFF_T0LIM, 16'h4321, 32'h00004321},
        {`TSR_OFF_T1LIM, 16'h8765, 32'h00008765}, {`TSR_OFF_SDLIM, SD, 16'h0000, SD},
        {`TSR_OFF_C0LIM, C0, 16'h0000, C0}, {`TSR_OFF_C1LIM, 16'hFFFF, 32'h0000FFFF},
        {`TSR_OFF_HOLD, H, 16'h0000, H}, {`TSR_OFF_ADJ, A, 16'h0000, A},
        {`TSR_OFF_LIT, 16'h5555, 32'h00005555}, {`TSR_OFF_QPTR, 16'hFFFF, 32'h0000001F},
        {8'h30, 16'hFFFF, 32'h00000000}};
    // copy, add, delay on, broadcast, loop, c0 and literal to select, park
    logic [15:0] prog [8] = '{16'h151D, 16'h0F06, 16'h0CC3, 16'hE70E,
                              16'h0000, 16'h0000, 16'h0000, 16'h0000};

    initial forever #5 clk = ~clk;
    tsr_register_set dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .compare_sync_pulse(sync), .compare1_clock_pulse(c1_clk),
        .converter_channel_select(sel), .converter_channel_load(ch_load));
    tsr_ahb_master bus (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task results;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // trigger output tally and timeout
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (c1_clk === 1'b1) begin
            n_clk  <= n_clk + 1;
            t_prev <= t_last;
            t_last <= cyc;
        end
        if (ch_load === 1'b1)
            n_ld <= n_ld + 1;
        for (int b = 0; b < 4; b++)
            if (sync[b] === 1'b1)
                n_sy[b] <= n_sy[b] + 1;
        if (cyc == 3000) begin
            fails++;
            results;
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            bus.xfer(1'b0, rows[i][55:48], 32'h0, rd);
            chk(rd, 32'h0);
            bus.xfer(1'b1, rows[i][55:48], {16'hA5A5, rows[i][47:32]}, rd);
            bus.xfer(1'b0, rows[i][55:48], 32'h0, rd);
            chk(rd, rows[i][31:0]);
        end
        bus.xfer(1'b1, `TSR_OFF_QPTR, 32'h0, rd);
        for (int i = 0; i < 8; i++) begin
            bus.xfer(1'b1, `TSR_OFF_QUE0 + 8'(4 * i), {16'h0000, prog[i]}, rd);
            bus.xfer(1'b0, `TSR_OFF_QUE0 + 8'(4 * i), 32'h0, rd);
            chk(rd, {16'h0000, prog[i]});
        end
        bus.xfer(1'b1, `TSR_OFF_CTRL, 32'h3, rd);
        for (int k = 0; k < 100 && rd !== 32'h7; k++)
            bus.xfer(1'b0, `TSR_OFF_QPTR, 32'h0, rd);
        chk(rd, 32'h7);
        bus.xfer(1'b1, `TSR_OFF_HOLD, 32'hBEEF, rd);
        bus.xfer(1'b0, `TSR_OFF_HOLD, 32'h0, rd);
        chk(rd, {16'h0000, H});
        bus.xfer(1'b1, 8'h4C, 32'h0, rd);
        bus.xfer(1'b0, 8'h4C, 32'h0, rd);
        chk(rd, {16'h0000, prog[3]});
        bus.xfer(1'b1, `TSR_OFF_CTRL, 32'h0, rd);
        bus.xfer(1'b0, `TSR_OFF_LIT, 32'h0, rd);
        chk(rd, {16'h0000, H + A});
        chk({16'h0000, sel}, {16'h0000, H + A});
        chk(n_ld, 32'h2);
        chk(n_clk, {16'h0000, C0 + 16'h0001});
        for (int b = 0; b < 4; b++)
            chk(n_sy[b], rows[0][32 + b] ? {16'h0000, C0 + 16'h0001} : 32'h0);
        chk(t_last - t_prev, {15'h0000, SD + 16'h0001, 1'b0});
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        bus.xfer(1'b0, `TSR_OFF_HOLD, 32'h0, rd);
        chk(rd, 32'h0);
        bus.xfer(1'b0, 8'h4C, 32'h0, rd);
        chk(rd, {16'h0000, prog[3]});
        clk_en <= 1'b0;
        bus.xfer(1'b1, `TSR_OFF_HOLD, 32'h7777, rd);
        clk_en <= 1'b1;
        bus.xfer(1'b0, `TSR_OFF_HOLD, 32'h0, rd);
        chk(rd, 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        results;
    end
endmodule

bind tsr_register_set tsr_monitor #(.QUE_WORDS(QUE_WORDS)) mon (.clk(clk), .resetn(resetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .compare_sync_pulse(compare_sync_pulse), .compare1_clock_pulse(compare1_clock_pulse),
    .converter_channel_select(converter_channel_select),
    .converter_channel_load(converter_channel_load));

// >>> verification/tsr_ahb_master.sv
/*
 * ahb-lite master standing in for processor software.
 * assumes: one slave whose hreadyout is fed back as hready.
 */
`timescale 1ns/1ps
module tsr_ahb_master (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel = 1'b0,
    output logic [31:0]      haddr = 32'h00000000,
    output logic [1:0]       htrans = 2'b00,
    output logic             hwrite = 1'b0,
    output logic [2:0]       hsize = 3'h2,
    output logic [31:0]      hwdata = 32'h00000000
);
    // one whole-word single transfer
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h000000, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        haddr  <= ~{24'h000000, a};
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        hwdata <= ~d;
    endtask
endmodule

// >>> verification/tsr_monitor.sv
/*
 * checker of the trigger sequencer register set ports.
 * assumes: bound to tsr_register_set, single word transfers, one master.
 */
`timescale 1ns/1ps
`include "tsr_defs.vh"
module tsr_monitor #(
    parameter QUE_WORDS = 8
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic [3:0]  compare_sync_pulse,
    input wire logic        compare1_clock_pulse,
    input wire logic [15:0] converter_channel_select,
    input wire logic        converter_channel_load
);
    // ------------------------------------------------------------
    // shadow of what software may change
    // ------------------------------------------------------------
    logic        ap;
    logic        aw;
    logic        run;
    logic        p_ok;
    logic        q_ok = 1'b0;
    logic [7:0]  aa;
    logic [4:0]  bte_sh;
    logic [4:0]  qp_sh;
    logic [15:0] hold_sh;
    logic [15:0] q3_sh;
    wire         rd = ap && !aw;
    wire         wr = ap && aw && clk_en;
    always @(posedge clk) begin
        if (!resetn) begin
            ap      <= 1'b0;
            run     <= 1'b0;
            p_ok    <= 1'b0;
            bte_sh  <= 5'h00;
            qp_sh   <= 5'h00;
            hold_sh <= 16'h0000;
        end else if (clk_en) begin
            ap <= hsel && hready && htrans[1];
            aw <= hwrite;
            aa <= haddr[7:0];
            if (run)
                p_ok <= 1'b0;
            if (wr && aa == `TSR_OFF_CTRL)
                run <= &hwdata[1:0];
            if (wr && !run && aa == `TSR_OFF_BTE)
                bte_sh <= hwdata[4:0];
            if (wr && !run && aa == `TSR_OFF_HOLD)
                hold_sh <= hwdata[15:0];
            if (wr && !run && aa == `TSR_OFF_QPTR) begin
                qp_sh <= hwdata[4:0];
                p_ok  <= 1'b1;
            end
        end
    end
    // queue word shadow survives reset
    always @(posedge clk)
        if (resetn && wr && !run && aa == 8'h4C) begin
            q3_sh <= hwdata[15:0];
            q_ok  <= 1'b1;
        end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_qptr_upper;
        rd && aa == `TSR_OFF_QPTR |-> hrdata[31:5] == 27'h0000000;
    endproperty
    a_qptr_upper: assert property (p_qptr_upper) else $error("pointer upper bits");
    property p_qptr_val;
        rd && p_ok && aa == `TSR_OFF_QPTR |-> hrdata[4:0] == qp_sh;
    endproperty
    a_qptr_val: assert property (p_qptr_val) else $error("pointer value");
    property p_bte_ro;
        rd && aa == `TSR_OFF_BTE |-> hrdata[4:0] == bte_sh;
    endproperty
    a_bte_ro: assert property (p_bte_ro) else $error("broadcast enable value");
    property p_hold_ro;
        rd && aa == `TSR_OFF_HOLD |-> hrdata[15:0] == hold_sh;
    endproperty
    a_hold_ro: assert property (p_hold_ro) else $error("hold value");
    property p_queue_keep;
        rd && q_ok && aa == 8'h4C |-> hrdata[15:0] == q3_sh;
    endproperty
    a_queue_keep: assert property (p_queue_keep) else $error("queue word lost");
    property p_queue_w;
        rd && aa >= `TSR_OFF_QUE0 && aa <= 8'h5C |-> hrdata[31:16] == 16'h0000;
    endproperty
    a_queue_w: assert property (p_queue_w) else $error("queue word width");
    property p_quiet;
        !run && !$past(run) && !$past(run, 2) |-> compare_sync_pulse == 4'h0
            && !compare1_clock_pulse && !converter_channel_load;
    endproperty
    a_quiet: assert property (p_quiet) else $error("output while stopped");
    property p_sel;
        $changed(converter_channel_select) |-> converter_channel_load;
    endproperty
    a_sel: assert property (p_sel) else $error("select moved unloaded");
endmodule
